// ### shared/adc_out_regs.svh
// Constants for the dual converter output control block
`ifndef ADC_OUT_REGS_SVH
`define ADC_OUT_REGS_SVH

`define WORD_W          10
`define WORD_MSB        9
`define PIPE_DEPTH      5
`define WORD_ZERO       10'h000
`define WORD_TOP        10'h3FF
`define FMT_GND         2'h0
`define FMT_THIRD       2'h1
`define FMT_TWO_THIRD   2'h2
`define FMT_FULL        2'h3

`endif

// ### shared/adc_out_pkg.sv
// Types shared by the dual converter output control block
package adc_out_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_HIZ,
        MODE_NAP,
        MODE_SLEEP
    } chan_mode_type;

endpackage

// ### core/sync2.sv
// Two-stage synchroniser for a single level
`timescale 1ns/1ps
module sync2 (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// ### core/sample_pipe.sv
// Five-stage sample pipeline carrying a word and its range flag together
`timescale 1ns/1ps
`include "adc_out_regs.svh"
module sample_pipe (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 shift_i,
    input  wire logic [`WORD_W-1:0]   word_i,
    input  wire logic                 flag_i,
    output logic      [`WORD_W-1:0]   word_o,
    output logic                      flag_o
);
    logic [`WORD_W:0] stage_r [`PIPE_DEPTH];

    genvar g;
    generate
        for (g = 0; g < `PIPE_DEPTH; g++) begin : g_stage
            if (g == 0) begin : g_head
                always_ff @(posedge ref_clk_i) begin
                    if (!rst_n_i) begin
                        stage_r[g] <= '0;
                    end else if (shift_i) begin
                        stage_r[g] <= {flag_i, word_i};
                    end
                end
            end else begin : g_body
                always_ff @(posedge ref_clk_i) begin
                    if (!rst_n_i) begin
                        stage_r[g] <= '0;
                    end else if (shift_i) begin
                        stage_r[g] <= stage_r[g-1];
                    end
                end
            end
        end
    endgenerate

    assign word_o = stage_r[`PIPE_DEPTH-1][`WORD_W-1:0];
    assign flag_o = stage_r[`PIPE_DEPTH-1][`WORD_W];
endmodule

// ### core/dual_adc_output_control.sv
// Output side of a dual ten-bit pipelined converter: pipeline, format, swap, drive
`timescale 1ns/1ps
`include "adc_out_regs.svh"

module dual_adc_output_control
    import adc_out_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                chan_a_sample_clock_i,
    input  wire logic                chan_b_sample_clock_i,
    input  wire logic [`WORD_W-1:0]  chan_a_quantized_i,
    input  wire logic [`WORD_W-1:0]  chan_b_quantized_i,
    input  wire logic                chan_a_out_of_range_i,
    input  wire logic                chan_b_out_of_range_i,
    input  wire logic                output_bus_swap_i,
    input  wire logic                chan_a_power_down_i,
    input  wire logic                chan_b_power_down_i,
    input  wire logic                chan_a_output_enable_n_i,
    input  wire logic                chan_b_output_enable_n_i,
    input  wire logic [1:0]          format_level_i,
    output logic      [`WORD_W-1:0]  bus_a_word_o,
    output logic      [`WORD_W-1:0]  bus_b_word_o,
    output logic                     bus_a_range_flag_o,
    output logic                     bus_b_range_flag_o,
    output logic                     bus_a_oe_o,
    output logic                     bus_b_oe_o,
    output logic                     duty_stabilizer_on_o,
    output logic      [1:0]          chan_a_mode_o,
    output logic      [1:0]          chan_b_mode_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic clk_a_s;
    logic clk_b_s;
    logic swap_s;
    logic pd_a_s;
    logic pd_b_s;
    logic oen_a_s;
    logic oen_b_s;
    logic fmt0_s;
    logic fmt1_s;

    // Every control and sample clock pin passes two flops before any logic reads it
    sync2 u_sync_clk_a (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (chan_a_sample_clock_i),
        .q_o       (clk_a_s)
    );

    sync2 u_sync_clk_b (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (chan_b_sample_clock_i),
        .q_o       (clk_b_s)
    );

    sync2 u_sync_swap (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (output_bus_swap_i),
        .q_o       (swap_s)
    );

    sync2 u_sync_pd_a (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (chan_a_power_down_i),
        .q_o       (pd_a_s)
    );

    sync2 u_sync_pd_b (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (chan_b_power_down_i),
        .q_o       (pd_b_s)
    );

    sync2 u_sync_oen_a (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (chan_a_output_enable_n_i),
        .q_o       (oen_a_s)
    );

    sync2 u_sync_oen_b (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (chan_b_output_enable_n_i),
        .q_o       (oen_b_s)
    );

    sync2 u_sync_fmt0 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (format_level_i[0]),
        .q_o       (fmt0_s)
    );

    sync2 u_sync_fmt1 (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (format_level_i[1]),
        .q_o       (fmt1_s)
    );

    // Quantizer words are sampled only at a clock edge, after they settled
    logic [`WORD_W-1:0] q_a_r;
    logic [`WORD_W-1:0] q_b_r;
    logic               ovr_a_r;
    logic               ovr_b_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q_a_r   <= `WORD_ZERO;
            ovr_a_r <= 1'b0;
        end else begin
            q_a_r   <= chan_a_quantized_i;
            ovr_a_r <= chan_a_out_of_range_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q_b_r   <= `WORD_ZERO;
            ovr_b_r <= 1'b0;
        end else begin
            q_b_r   <= chan_b_quantized_i;
            ovr_b_r <= chan_b_out_of_range_i;
        end
    end

    // ------------------------------------------------------------
    // Sample clock edge detection
    // ------------------------------------------------------------
    logic clk_a_d_r;
    logic clk_b_d_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            clk_a_d_r <= 1'b0;
            clk_b_d_r <= 1'b0;
        end else begin
            clk_a_d_r <= clk_a_s;
            clk_b_d_r <= clk_b_s;
        end
    end

    // A pin already high at reset release shows up as one rise
    wire rise_a = clk_a_s & ~clk_a_d_r;
    wire rise_b = clk_b_s & ~clk_b_d_r;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    chan_mode_type mode_a;
    chan_mode_type mode_b;

    always_comb begin
        unique case ({pd_a_s, oen_a_s})
            2'b00: mode_a = MODE_NORMAL;
            2'b01: mode_a = MODE_HIZ;
            2'b10: mode_a = MODE_NAP;
            2'b11: mode_a = MODE_SLEEP;
        endcase
    end

    always_comb begin
        unique case ({pd_b_s, oen_b_s})
            2'b00: mode_b = MODE_NORMAL;
            2'b01: mode_b = MODE_HIZ;
            2'b10: mode_b = MODE_NAP;
            2'b11: mode_b = MODE_SLEEP;
        endcase
    end

    // Conversion runs only while not powered down
    wire conv_a = ~pd_a_s;
    wire conv_b = ~pd_b_s;
    wire drive_a = (mode_a == MODE_NORMAL);
    wire drive_b = (mode_b == MODE_NORMAL);

    // ------------------------------------------------------------
    // Pipelines
    // ------------------------------------------------------------
    logic [`WORD_W-1:0] pipe_a_word;
    logic [`WORD_W-1:0] pipe_b_word;
    logic               pipe_a_flag;
    logic               pipe_b_flag;

    // A powered-down channel stops shifting, so nap and sleep keep the last words
    sample_pipe u_pipe_a (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .shift_i   (rise_a & conv_a),
        .word_i    (q_a_r),
        .flag_i    (ovr_a_r),
        .word_o    (pipe_a_word),
        .flag_o    (pipe_a_flag)
    );

    sample_pipe u_pipe_b (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .shift_i   (rise_b & conv_b),
        .word_i    (q_b_r),
        .flag_i    (ovr_b_r),
        .word_o    (pipe_b_word),
        .flag_o    (pipe_b_flag)
    );

    // ------------------------------------------------------------
    // Format and stabilizer
    // ------------------------------------------------------------
    wire [1:0] fmt_lvl = {fmt1_s, fmt0_s};
    wire twos_sel = (fmt_lvl == `FMT_TWO_THIRD) | (fmt_lvl == `FMT_FULL);
    wire dcs_sel  = (fmt_lvl == `FMT_THIRD) | (fmt_lvl == `FMT_TWO_THIRD);

    // Format applies at the output, so words already in flight follow a change
    // Offset binary passes straight through, zero at bottom, all ones at top
    wire [`WORD_W-1:0] msb_flip = {1'b1, {(`WORD_W-1){1'b0}}};
    wire [`WORD_W-1:0] fmt_a = twos_sel ? (pipe_a_word ^ msb_flip) : pipe_a_word;
    wire [`WORD_W-1:0] fmt_b = twos_sel ? (pipe_b_word ^ msb_flip) : pipe_b_word;

    // ------------------------------------------------------------
    // Bus swap
    // ------------------------------------------------------------
    // The routed channel's mode decides whether its bus is driven
    wire [`WORD_W-1:0] bus_a_nxt  = swap_s ? fmt_a : fmt_b;
    wire [`WORD_W-1:0] bus_b_nxt  = swap_s ? fmt_b : fmt_a;
    wire               flag_a_nxt = swap_s ? pipe_a_flag : pipe_b_flag;
    wire               flag_b_nxt = swap_s ? pipe_b_flag : pipe_a_flag;
    wire               oe_a_nxt   = swap_s ? drive_a : drive_b;
    wire               oe_b_nxt   = swap_s ? drive_b : drive_a;

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_a_word_o <= `WORD_ZERO;
            bus_b_word_o <= `WORD_ZERO;
        end else begin
            bus_a_word_o <= bus_a_nxt;
            bus_b_word_o <= bus_b_nxt;
        end
    end

    // Range flags ride in the same cycle as their words
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_a_range_flag_o <= 1'b0;
            bus_b_range_flag_o <= 1'b0;
        end else begin
            bus_a_range_flag_o <= flag_a_nxt;
            bus_b_range_flag_o <= flag_b_nxt;
        end
    end

    // Drive enables
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bus_a_oe_o <= 1'b0;
            bus_b_oe_o <= 1'b0;
        end else begin
            bus_a_oe_o <= oe_a_nxt;
            bus_b_oe_o <= oe_b_nxt;
        end
    end

    // Status
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            duty_stabilizer_on_o <= 1'b0;
            chan_a_mode_o        <= 2'h0;
            chan_b_mode_o        <= 2'h0;
        end else begin
            duty_stabilizer_on_o <= dcs_sel;
            chan_a_mode_o        <= mode_a;
            chan_b_mode_o        <= mode_b;
        end
    end
endmodule

// ### bench/dual_adc_output_control_asserts.sv
// Port-level assertions for the dual converter output control block
`timescale 1ns/1ps
`include "adc_out_regs.svh"
module dual_adc_checks (
    input wire logic               ref_clk_i,
    input wire logic               rst_n_i,
    input wire logic               output_bus_swap_i,
    input wire logic               chan_a_power_down_i,
    input wire logic               chan_b_power_down_i,
    input wire logic               chan_a_output_enable_n_i,
    input wire logic               chan_b_output_enable_n_i,
    input wire logic [1:0]         format_level_i,
    input wire logic [`WORD_W-1:0] bus_a_word_o,
    input wire logic [`WORD_W-1:0] bus_b_word_o,
    input wire logic               bus_a_range_flag_o,
    input wire logic               bus_b_range_flag_o,
    input wire logic               bus_a_oe_o,
    input wire logic               bus_b_oe_o,
    input wire logic               duty_stabilizer_on_o,
    input wire logic [1:0]         chan_a_mode_o,
    input wire logic [1:0]         chan_b_mode_o
);
    wire pd_both  = chan_a_mode_o[1] && chan_b_mode_o[1];
    wire off_both = (chan_a_mode_o != 2'h0) && (chan_b_mode_o != 2'h0);
    wire on_both  = (chan_a_mode_o == 2'h0) && (chan_b_mode_o == 2'h0);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    chan_a_mode_a: assert property (($stable(chan_a_power_down_i)
        && $stable(chan_a_output_enable_n_i))[*6]
        |-> chan_a_mode_o == {chan_a_power_down_i, chan_a_output_enable_n_i})
        else $error("channel A mode wrong");
    chan_b_mode_a: assert property (($stable(chan_b_power_down_i)
        && $stable(chan_b_output_enable_n_i))[*6]
        |-> chan_b_mode_o == {chan_b_power_down_i, chan_b_output_enable_n_i})
        else $error("channel B mode wrong");
    bus_a_off_a: assert property (off_both[*2] |-> !bus_a_oe_o)
        else $error("bus A driven while idle");
    bus_b_off_a: assert property (off_both[*2] |-> !bus_b_oe_o)
        else $error("bus B driven while idle");
    buses_on_a: assert property (on_both[*2] |-> bus_a_oe_o && bus_b_oe_o)
        else $error("bus not driven in normal mode");
    duty_level_a: assert property ($stable(format_level_i)[*6]
        |-> duty_stabilizer_on_o == (format_level_i inside {2'h1, 2'h2}))
        else $error("stabilizer state wrong");
    nap_hold_a_a: assert property ((pd_both && $stable(format_level_i)
        && $stable(output_bus_swap_i))[*5] |-> $stable({bus_a_word_o, bus_a_range_flag_o}))
        else $error("bus A moved while stopped");
    nap_hold_b_a: assert property ((pd_both && $stable(format_level_i)
        && $stable(output_bus_swap_i))[*5] |-> $stable({bus_b_word_o, bus_b_range_flag_o}))
        else $error("bus B moved while stopped");
endmodule
bind dual_adc_output_control dual_adc_checks dual_adc_checks_inst (.*);

// ### bench/capture_model.sv
// Capture side model: sample clocks and resolved output buses
`timescale 1ns/1ps
module capture_model (
    input  wire logic        ref_clk_i,
    input  wire logic [10:0] drv_a_i,
    input  wire logic [10:0] drv_b_i,
    input  wire logic        oe_a_i,
    input  wire logic        oe_b_i,
    output logic             clk_a_o,
    output logic             clk_b_o,
    output logic      [10:0] seen_a_o,
    output logic      [10:0] seen_b_o
);
    logic [10:0] last_a_r;
    logic [10:0] last_b_r;
    int          cnt = 0;
    initial begin
        {clk_a_o, clk_b_o} = 2'h0;
        forever begin
            @(posedge ref_clk_i);
            #1;
            cnt++;
            if (cnt % 4 == 0) clk_a_o = ~clk_a_o;
            if (cnt % 5 == 0) clk_b_o = ~clk_b_o;
        end
    end
    // A released bus shows the inverse of its last driven value
    always @(posedge ref_clk_i) begin
        if (oe_a_i) last_a_r <= drv_a_i;
        if (oe_b_i) last_b_r <= drv_b_i;
    end
    assign seen_a_o = oe_a_i ? drv_a_i : ~last_a_r;
    assign seen_b_o = oe_b_i ? drv_b_i : ~last_b_r;
endmodule

// ### bench/dual_adc_output_control_bench.sv
// Self-checking bench for the dual converter output control block
`timescale 1ns/1ps
`include "adc_out_regs.svh"
module dual_adc_output_control_bench;
    logic               ref_clk_i, rst_n_i, run, sw, pd_a, pd_b, oen_a, oen_b, fa, fb;
    logic [1:0]         fmt, ma, mb;
    logic [`WORD_W-1:0] qa, qb, ba, bb;
    logic               fla, flb, chan_a_output_enable_n, chan_b_output_enable_n, stab, clk_a, clk_b;
    logic [10:0]        seen_a, seen_b, note_a[$], note_b[$];
    int                 err_total = 0;
    int                 checks_done = 0;
    dual_adc_output_control dual_adc_output_control_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .chan_a_sample_clock_i(clk_a),
        .chan_b_sample_clock_i(clk_b), .chan_a_quantized_i(qa), .chan_b_quantized_i(qb),
        .chan_a_out_of_range_i(fa), .chan_b_out_of_range_i(fb), .output_bus_swap_i(sw),
        .chan_a_power_down_i(pd_a), .chan_b_power_down_i(pd_b),
        .chan_a_output_enable_n_i(oen_a), .chan_b_output_enable_n_i(oen_b),
        .format_level_i(fmt), .bus_a_word_o(ba), .bus_b_word_o(bb),
        .bus_a_range_flag_o(fla), .bus_b_range_flag_o(flb), .bus_a_oe_o(chan_a_output_enable_n),
        .bus_b_oe_o(chan_b_output_enable_n), .duty_stabilizer_on_o(stab), .chan_a_mode_o(ma),
        .chan_b_mode_o(mb));
    capture_model capture_model_inst (
        .ref_clk_i(ref_clk_i), .drv_a_i({fla, ba}), .drv_b_i({flb, bb}), .oe_a_i(chan_a_output_enable_n),
        .oe_b_i(chan_b_output_enable_n), .clk_a_o(clk_a), .clk_b_o(clk_b), .seen_a_o(seen_a),
        .seen_b_o(seen_b));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
        checks_done++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Random word and flag, with the range ends mixed in
    function automatic logic [10:0] pick;
        logic [10:0] v;
        v = 11'($urandom);
        if (v[3:2] == 2'h0) v[9:0] = v[4] ? `WORD_TOP : `WORD_ZERO;
        return v;
    endfunction
    function automatic logic [10:0] expv(input logic [10:0] n);
        return n ^ {1'b0, fmt[1], 9'h000};
    endfunction
    // Drivers note each sampled word; watchers compare it six rises after the note
    always @(negedge clk_a) if (run) begin
        {fa, qa} = pick();
        note_a.push_back({fa, qa});
    end
    always @(negedge clk_b) if (run) begin
        {fb, qb} = pick();
        note_b.push_back({fb, qb});
    end
    always @(posedge clk_a) if (note_a.size() > 5)
        chk("A word", expv(note_a.pop_front()), sw ? seen_a : seen_b);
    always @(posedge clk_b) if (note_b.size() > 5)
        chk("B word", expv(note_b.pop_front()), sw ? seen_b : seen_a);
    initial begin
        {rst_n_i, run, sw, pd_a, pd_b, oen_a, oen_b, fa, fb, fmt, qa, qb} = '0;
        void'($urandom(32'hB28B));
        repeat (3) @(posedge ref_clk_i);
        chk("reset output", 11'h000, {fla, ba});
        #1 rst_n_i = 1'b1;
        for (int p = 0; p < 8; p++) begin
            @(posedge ref_clk_i);
            #1 {fmt, sw} = 3'(p);
            @(negedge ref_clk_i);
            run = 1'b1;
            repeat (120) @(posedge ref_clk_i);
            chk("stabilizer", 11'(fmt inside {2'h1, 2'h2}), 11'(stab));
            @(negedge ref_clk_i);
            run = 1'b0;
            note_a.delete();
            note_b.delete();
        end
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk_i);
            #1 {pd_a, oen_a} = 2'(m);
            {pd_b, oen_b} = 2'(m ^ 1);
            repeat (12) @(posedge ref_clk_i);
            #1 chk("mode A", 11'(m), 11'(ma));
            chk("mode B", 11'(m ^ 1), 11'(mb));
            chk("bus A drive", 11'(m == 0), 11'(chan_a_output_enable_n));
            chk("bus B drive", 11'(m == 1), 11'(chan_b_output_enable_n));
        end
        test_done();
    end
endmodule
